// ---- eth_mac_tx_stats_rx_ctrl.sv ----
// Transmit statistics pulses, transmit status levels and receive control for one Ethernet port.
//
// Behaviour
// R1: Pulse the 1523-1548 byte bin once per sent packet, good or bad.
// R2: Pulse the 1549-2047 byte bin once per sent packet, good or bad.
// R3: Pulse the 2048-4095 byte bin once per sent packet, good or bad.
// R4: Pulse the 4096-8191 byte bin once per sent packet, good or bad.
// R5: Pulse the 8192-9215 byte bin once per sent packet, good or bad.
// R6: Pulse undersize once per sent packet shorter than 64 bytes.
// R7: Pulse oversize once per sent packet longer than 9215 bytes.
// R8: Pulse bad checksum for sent packets over 64 bytes with a bad check sequence.
// R9: Pulse frame error for each packet the user aborted with its error marker.
// R10: Hold local fault high as a level while the encoder stays in its initial state.
// R11: Raise the FIFO error when the compensation FIFO underflows or overflows.
// R12: Once the FIFO error is seen, the port must be reset to recover.
// R13: A set test pattern control puts the receiver into test mode.
// R14: In test mode the receiver checks for the scrambled idle pattern.
// R15: Dropping receive enable finishes the current packet and then stops receiving.
// R16: While receive is disabled no receive statistics and an idle user interface.
// R17: Normal operation needs receive enable held at one.
// R18: With checksum removal off, packets reach the user with the check sequence.
// R19: With checksum removal on, the check sequence is stripped before delivery.
// R20: Packets of 8 bytes or fewer keep their check sequence regardless.
// R21: Checksum removal should only be changed while the port is held in reset.
// R22: Each statistics output is a single cycle pulse at packet completion.
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps

module eth_mac_tx_stats_rx_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM register slave.
  input wire logic [eth_stats_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Transmit packet monitor.
  input eth_stats_pkg::beat_t txBeat,
  input wire logic txErrIn,
  input wire logic txFcsBad,
  output eth_stats_pkg::txStats_t txStats,
  // Transmit status.
  input wire logic pcsAligned,
  input wire logic ccPush,
  input wire logic ccPop,
  output logic txLocalFault,
  output logic txFifoError,
  // Receive side.
  input eth_stats_pkg::beat_t rxInBeat,
  input wire logic rxBlkValid,
  input wire logic rxBlkIsIdle,
  output eth_stats_pkg::beat_t rxOutBeat,
  output logic rxPacketStat
);
  import eth_stats_pkg::*;

  // ****************************************
  // Register bus
  // ****************************************
  logic ack_reg;
  logic [2:0] ctrl_reg;
  logic [31:0] testErr_reg;
  logic rxActive_reg;
  logic busRead;
  logic busWrite;
  logic testErrHit;

  // Every access takes exactly one wait cycle, so read data always comes from a flip-flop.
  assign waitrequest = (read | write) & ~ack_reg;
  assign busWrite = write & ack_reg;
  assign busRead = read & ~ack_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (busWrite && address == OFF_CTRL) begin
      ctrl_reg[CTRL_RXEN_BIT] <= writedata[CTRL_RXEN_BIT]; // R17
      ctrl_reg[CTRL_TEST_BIT] <= writedata[CTRL_TEST_BIT]; // R13
      ctrl_reg[CTRL_DELFCS_BIT] <= writedata[CTRL_DELFCS_BIT]; // R19
    end
  end

  // Status bits are placed by name, so a moved field cannot shift its neighbours.
  logic [31:0] statusWord;

  always_comb begin
    statusWord = 32'h0;
    statusWord[STAT_LFAULT_BIT] = txLocalFault; // R10
    statusWord[STAT_FIFOERR_BIT] = txFifoError; // R11
    statusWord[STAT_RXACT_BIT] = rxActive_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0;
    end else if (busRead) begin
      case (address)
        OFF_CTRL: readdata <= {29'h0, ctrl_reg};
        OFF_STATUS: readdata <= statusWord;
        OFF_TESTERR: readdata <= testErr_reg;
        default: readdata <= 32'h0;
      endcase
    end
  end

  logic rxEnable;
  logic testMode;
  logic deleteFcs;
  assign rxEnable = ctrl_reg[CTRL_RXEN_BIT];
  assign testMode = ctrl_reg[CTRL_TEST_BIT]; // R13
  assign deleteFcs = ctrl_reg[CTRL_DELFCS_BIT];

  // ****************************************
  // Transmit length and size bins
  // ****************************************
  function automatic logic [LEN_W-1:0] addLen(input logic [LEN_W-1:0] base, input logic [BYTES_W-1:0] n);
    logic [LEN_W:0] sum;
    sum = {1'b0, base} + {{(LEN_W+1-BYTES_W){1'b0}}, n};
    // Saturate so very long frames still land in the oversize bin.
    addLen = sum[LEN_W] ? LEN_MAX : sum[LEN_W-1:0];
  endfunction

  function automatic logic inRange(input logic [LEN_W-1:0] len, input logic [LEN_W-1:0] lo,
                                   input logic [LEN_W-1:0] hi);
    inRange = (len >= lo) && (len <= hi);
  endfunction

  logic [LEN_W-1:0] txLen_reg;
  logic [LEN_W-1:0] txLenNow;
  logic [BYTES_W-1:0] txBeatBytes;

  assign txBeatBytes = txBeat.eop ? txBeat.bytes : BEAT_FULL;
  assign txLenNow = addLen(txBeat.sop ? '0 : txLen_reg, txBeatBytes);

  // Bounds of the five large size bins, lowest bin first.
  localparam int BIN_COUNT = 5;
  localparam logic [LEN_W-1:0] BIN_LO [BIN_COUNT] = '{LEN_1523, LEN_1549, LEN_2048, LEN_4096, LEN_8192};
  localparam logic [LEN_W-1:0] BIN_HI [BIN_COUNT] = '{LEN_1548, LEN_2047, LEN_4095, LEN_8191, LEN_9215};
  logic [BIN_COUNT-1:0] binHit;

  for (genvar b = 0; b < BIN_COUNT; b++) begin : g_bin
    assign binHit[b] = inRange(txLenNow, BIN_LO[b], BIN_HI[b]);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txLen_reg <= '0;
    end else if (txBeat.valid) begin
      txLen_reg <= txLenNow;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txStats <= '0;
    end else begin
      txStats <= '0; // R22
      if (txBeat.valid && txBeat.eop) begin
        txStats.bin1523to1548 <= binHit[0]; // R1
        txStats.bin1549to2047 <= binHit[1]; // R2
        txStats.bin2048to4095 <= binHit[2]; // R3
        txStats.bin4096to8191 <= binHit[3]; // R4
        txStats.bin8192to9215 <= binHit[4]; // R5
        txStats.undersize <= txLenNow < LEN_SMALL_LT; // R6
        txStats.oversize <= txLenNow > LEN_9215; // R7
        txStats.badFcs <= txFcsBad && (txLenNow > LEN_BADFCS_GT); // R8
        txStats.frameError <= txErrIn; // R9
      end
    end
  end

  // ****************************************
  // Encoder state and local fault
  // ****************************************
  logic alignMeta_reg;
  logic alignSync_reg;
  // Leaving the initial state waits for the synchronised alignment, never the raw pin.
  encState_t encState_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alignMeta_reg <= 1'b0;
      alignSync_reg <= 1'b0;
    end else begin
      alignMeta_reg <= pcsAligned;
      alignSync_reg <= alignMeta_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      encState_reg <= encInit;
    end else begin
      case (encState_reg)
        encInit: encState_reg <= alignSync_reg ? encRun : encInit;
        encRun: encState_reg <= alignSync_reg ? encRun : encInit;
        default: encState_reg <= encInit;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txLocalFault <= 1'b1;
    end else begin
      txLocalFault <= (encState_reg == encInit); // R10
    end
  end

  // ****************************************
  // Clock compensation FIFO watch
  // ****************************************
  // The fill stops at its ends, so an error cannot wrap the count.
  logic [CC_PTR_W-1:0] ccFill_reg;
  logic ccOver;
  logic ccUnder;

  assign ccOver = ccPush && !ccPop && (ccFill_reg == CC_DEPTH);
  assign ccUnder = ccPop && !ccPush && (ccFill_reg == '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ccFill_reg <= '0;
    end else if (ccPush && !ccPop && !ccOver) begin
      ccFill_reg <= ccFill_reg + 1'b1;
    end else if (ccPop && !ccPush && !ccUnder) begin
      ccFill_reg <= ccFill_reg - 1'b1;
    end
  end

  // The flag is sticky: only a port reset clears it, since data is already lost.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txFifoError <= 1'b0;
    end else if (ccOver || ccUnder) begin
      txFifoError <= 1'b1; // R11 R12
    end
  end

  // ****************************************
  // Receive test pattern checker
  // ****************************************
  assign testErrHit = testMode && rxBlkValid && !rxBlkIsIdle; // R14

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      testErr_reg <= 32'h0;
    end else if (busWrite && address == OFF_TESTERR) begin
      // A mismatch in the clearing cycle is still counted.
      testErr_reg <= {31'h0, testErrHit};
    end else if (testErrHit && testErr_reg != ERRCNT_MAX) begin
      testErr_reg <= testErr_reg + 32'h1;
    end
  end

  // ****************************************
  // Receive gating and check sequence removal
  // ****************************************
  logic rxInPkt_reg;
  logic rxAccept;
  logic [LEN_W-1:0] rxLen_reg;
  logic [LEN_W-1:0] rxLenNow;
  logic [BYTES_W-1:0] rxBeatBytes;
  beat_t hold_reg;
  logic strip;
  logic stripShort;

  // Enable and test mode are sampled only at a start of packet, so a packet in flight completes.
  assign rxAccept = rxInBeat.valid && (rxInBeat.sop ? (rxEnable && !testMode) : rxInPkt_reg); // R15 R16
  assign rxBeatBytes = rxInBeat.eop ? rxInBeat.bytes : BEAT_FULL;
  assign rxLenNow = addLen(rxInBeat.sop ? '0 : rxLen_reg, rxBeatBytes);
  assign strip = deleteFcs && rxInBeat.eop && (rxLenNow > FCS_KEEP_MAX); // R19 R20
  assign stripShort = strip && (rxInBeat.bytes <= FCS_BYTES);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxInPkt_reg <= 1'b0;
      rxLen_reg <= '0;
    end else if (rxAccept) begin
      rxInPkt_reg <= !rxInBeat.eop;
      rxLen_reg <= rxLenNow;
    end else if (rxInBeat.valid && rxInBeat.sop) begin
      rxInPkt_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxActive_reg <= 1'b0;
    end else if (rxInBeat.valid && rxInBeat.sop) begin
      rxActive_reg <= rxAccept && !rxInBeat.eop;
    end else if (rxAccept && rxInBeat.eop) begin
      rxActive_reg <= 1'b0;
    end
  end

  // One beat is held back so a check sequence split across two beats can be trimmed.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= '0;
    end else if (rxAccept && stripShort) begin
      hold_reg <= '0;
    end else if (rxAccept) begin
      hold_reg <= rxInBeat;
      hold_reg.valid <= 1'b1;
      if (strip) begin
        hold_reg.bytes <= rxInBeat.bytes - FCS_BYTES; // R19
      end
    end else if (hold_reg.valid && hold_reg.eop) begin
      hold_reg <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxOutBeat <= '0;
      rxPacketStat <= 1'b0;
    end else begin
      rxOutBeat <= '0;
      rxPacketStat <= 1'b0;
      if (hold_reg.valid && (rxAccept || hold_reg.eop)) begin
        rxOutBeat <= hold_reg; // R18
        rxPacketStat <= hold_reg.eop; // R16 R22
        if (rxAccept && stripShort) begin
          rxOutBeat.eop <= 1'b1;
          rxOutBeat.bytes <= BEAT_FULL - (FCS_BYTES - rxInBeat.bytes);
          rxPacketStat <= 1'b1;
        end
      end
    end
  end

endmodule // eth_mac_tx_stats_rx_ctrl

// ---- eth_mac_tx_stats_rx_ctrl_monitor.sv ----
// Concurrent checks on the statistics and receive control ports.
`timescale 1ns/100ps
module eth_stats_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input eth_stats_pkg::beat_t txBeat,
  input wire logic txErrIn,
  input wire logic txFcsBad,
  input eth_stats_pkg::txStats_t txStats,
  input wire logic pcsAligned,
  input wire logic ccPush,
  input wire logic ccPop,
  input wire logic txLocalFault,
  input wire logic txFifoError,
  input eth_stats_pkg::beat_t rxOutBeat,
  input wire logic rxPacketStat
);
  import eth_stats_pkg::*;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_pulse_at_eop: assert property (txStats != '0 |-> $past(txBeat.valid && txBeat.eop))
    else $error("statistics pulse without an end of packet");
  chk_abort_mark: assert property (txBeat.valid && txBeat.eop |=> txStats.frameError == $past(txErrIn))
    else $error("frame error pulse does not follow the abort marker");
  chk_bad_sum: assert property (txStats.badFcs |-> $past(txFcsBad))
    else $error("bad checksum pulse without a bad check sequence");
  chk_short_frame: assert property (txBeat.valid && txBeat.sop && txBeat.eop |=> txStats.undersize && !txStats.badFcs)
    else $error("single beat packet not counted as undersize");
  chk_one_bin: assert property ($onehot0(txStats[8:2]))
    else $error("more than one size bin pulsed");
  chk_fault_hold: assert property ($fell(txLocalFault) |-> $past(pcsAligned, 3))
    else $error("local fault dropped too early");
  chk_fifo_sticky: assert property (txFifoError |=> txFifoError)
    else $error("fifo error cleared without reset");
  chk_fifo_cause: assert property ($rose(txFifoError) |-> $past(ccPush != ccPop))
    else $error("fifo error without a lone push or pop");
  chk_rx_stat_eop: assert property (rxPacketStat |-> rxOutBeat.valid && rxOutBeat.eop)
    else $error("receive statistic without a delivered end of packet");
  chk_bus_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("register access waited more than one cycle");
endmodule // eth_stats_monitor

bind eth_mac_tx_stats_rx_ctrl eth_stats_monitor u_mon (.clk(clk), .rst_n(rst_n), .read(read), .write(write),
  .waitrequest(waitrequest), .txBeat(txBeat), .txErrIn(txErrIn), .txFcsBad(txFcsBad), .txStats(txStats),
  .pcsAligned(pcsAligned), .ccPush(ccPush), .ccPop(ccPop), .txLocalFault(txLocalFault),
  .txFifoError(txFifoError), .rxOutBeat(rxOutBeat), .rxPacketStat(rxPacketStat));

// ---- eth_stats_pkg.sv ----
// Shared constants and types for the port statistics and receive control block.
package eth_stats_pkg;

  // ****************************************
  // Data path geometry
  // ****************************************
  localparam int BEAT_BYTES = 16;
  localparam int BYTES_W = 5;
  localparam int LEN_W = 14;
  localparam logic [LEN_W-1:0] LEN_MAX = 14'h3fff;
  localparam logic [BYTES_W-1:0] BEAT_FULL = 5'h10;

  // ****************************************
  // Transmit size bins (frame length including the check sequence)
  // ****************************************
  localparam logic [LEN_W-1:0] LEN_SMALL_LT = 14'd64;
  localparam logic [LEN_W-1:0] LEN_BADFCS_GT = 14'd64;
  localparam logic [LEN_W-1:0] LEN_1523 = 14'd1523;
  localparam logic [LEN_W-1:0] LEN_1548 = 14'd1548;
  localparam logic [LEN_W-1:0] LEN_1549 = 14'd1549;
  localparam logic [LEN_W-1:0] LEN_2047 = 14'd2047;
  localparam logic [LEN_W-1:0] LEN_2048 = 14'd2048;
  localparam logic [LEN_W-1:0] LEN_4095 = 14'd4095;
  localparam logic [LEN_W-1:0] LEN_4096 = 14'd4096;
  localparam logic [LEN_W-1:0] LEN_8191 = 14'd8191;
  localparam logic [LEN_W-1:0] LEN_8192 = 14'd8192;
  localparam logic [LEN_W-1:0] LEN_9215 = 14'd9215;

  // ****************************************
  // Receive check sequence handling
  // ****************************************
  localparam logic [BYTES_W-1:0] FCS_BYTES = 5'h04;
  localparam logic [LEN_W-1:0] FCS_KEEP_MAX = 14'd8;

  // ****************************************
  // Clock compensation FIFO occupancy model
  // ****************************************
  localparam int CC_PTR_W = 5;
  localparam logic [CC_PTR_W-1:0] CC_DEPTH = 5'h10;

  // ****************************************
  // Register map (byte addresses on the Avalon-MM slave)
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_TESTERR = 4'h8;
  localparam int CTRL_RXEN_BIT = 0;
  localparam int CTRL_TEST_BIT = 1;
  localparam int CTRL_DELFCS_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  localparam int STAT_LFAULT_BIT = 0;
  localparam int STAT_FIFOERR_BIT = 1;
  localparam int STAT_RXACT_BIT = 2;
  localparam logic [31:0] ERRCNT_MAX = 32'hffffffff;

  typedef struct packed {
    logic bin1523to1548;
    logic bin1549to2047;
    logic bin2048to4095;
    logic bin4096to8191;
    logic bin8192to9215;
    logic undersize;
    logic oversize;
    logic badFcs;
    logic frameError;
  } txStats_t;

  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [BYTES_W-1:0] bytes;
    logic [BEAT_BYTES*8-1:0] data;
  } beat_t;

  typedef enum logic {encInit, encRun} encState_t;

endpackage

// ---- stats_collector.sv ----
// Statistics collector model that tallies every increment pulse.
`timescale 1ns/100ps
module stats_collector (
  input wire logic clk,
  input eth_stats_pkg::txStats_t txStats,
  input wire logic rxPacketStat,
  output int txCount,
  output int rxCount
);
  import eth_stats_pkg::*;
  // Never cleared, so a port reset cannot hide a lost or doubled pulse.
  int txTally = 0;
  int rxTally = 0;
  assign txCount = txTally;
  assign rxCount = rxTally;
  always @(posedge clk) begin
    txTally <= txTally + $countones(txStats);
    rxTally <= rxTally + int'(rxPacketStat);
  end
endmodule // stats_collector

// ---- tb_eth_mac_tx_stats_rx_ctrl.sv ----
// Self-checking bench for the port statistics and receive control block.
`timescale 1ns/100ps
module tb_eth_mac_tx_stats_rx_ctrl;
  import eth_stats_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = '0;
  logic [31:0] readdata;
  logic waitrequest;
  beat_t txBeat = '0;
  logic txErrIn = 1'b0;
  logic txFcsBad = 1'b0;
  txStats_t txStats;
  logic pcsAligned = 1'b0;
  logic ccPush = 1'b0;
  logic ccPop = 1'b0;
  logic txLocalFault;
  logic txFifoError;
  beat_t rxInBeat = '0;
  logic rxBlkValid = 1'b0;
  logic rxBlkIsIdle = 1'b0;
  beat_t rxOutBeat;
  logic rxPacketStat;
  int txCount;
  int rxCount;
  int badCount = 0;
  int compares = 0;
  int rxBytes = 0;
  int expTx = 0;
  int expRx = 0;
  logic [31:0] rnd = 32'h153bd;
  logic [31:0] rd;
  int corner[18] = '{1, 16, 17, 63, 64, 65, 1522, 1523, 1548, 1549, 2047, 2048, 4095, 4096, 8191, 8192, 9215, 9216};
  int rxLen[8] = '{5, 8, 9, 12, 17, 20, 33, 100};
  always #2 clk = ~clk;
  eth_mac_tx_stats_rx_ctrl u_dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .txBeat(txBeat), .txErrIn(txErrIn),
    .txFcsBad(txFcsBad), .txStats(txStats), .pcsAligned(pcsAligned), .ccPush(ccPush), .ccPop(ccPop),
    .txLocalFault(txLocalFault), .txFifoError(txFifoError), .rxInBeat(rxInBeat), .rxBlkValid(rxBlkValid),
    .rxBlkIsIdle(rxBlkIsIdle), .rxOutBeat(rxOutBeat), .rxPacketStat(rxPacketStat));
  stats_collector u_stats (.clk(clk), .txStats(txStats), .rxPacketStat(rxPacketStat), .txCount(txCount),
    .rxCount(rxCount));
  always @(negedge clk) if (rxOutBeat.valid === 1'b1) rxBytes += rxOutBeat.eop ? int'(rxOutBeat.bytes) : 16;
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic txStats_t expStats(input int len, input logic err, input logic bad);
    txStats_t e;
    e = '0;
    e.bin1523to1548 = len >= LEN_1523 && len <= LEN_1548;
    e.bin1549to2047 = len >= LEN_1549 && len <= LEN_2047;
    e.bin2048to4095 = len >= LEN_2048 && len <= LEN_4095;
    e.bin4096to8191 = len >= LEN_4096 && len <= LEN_8191;
    e.bin8192to9215 = len >= LEN_8192 && len <= LEN_9215;
    e.undersize = len < LEN_SMALL_LT;
    e.oversize = len > LEN_9215;
    e.badFcs = bad && len > LEN_BADFCS_GT;
    e.frameError = err;
    return e;
  endfunction
  function automatic beat_t makeBeat(input int len, input int i);
    beat_t b;
    rnd = nextRand(rnd);
    b.valid = 1'b1;
    b.sop = i == 0;
    b.eop = i == (len + 15) / 16 - 1;
    b.bytes = b.eop ? 5'(len - 16 * i) : BEAT_FULL;
    b.data = {4{rnd}};
    return b;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic completeRun();
    $display("mismatches %0d compares %0d", badCount, compares);
    if (badCount == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic busCycle(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic sendTx(input int len, input logic err, input logic bad);
    txStats_t e;
    e = expStats(len, err, bad);
    for (int i = 0; i < (len + 15) / 16; i++) begin
      @(posedge clk);
      txBeat <= makeBeat(len, i);
      txErrIn <= err;
      txFcsBad <= bad;
    end
    @(posedge clk);
    txBeat <= '0;
    @(negedge clk);
    check({23'h0, txStats}, {23'h0, e}, "txStats");
    expTx += $countones(e);
  endtask
  task automatic sendRx(input int len);
    for (int i = 0; i < (len + 15) / 16; i++) begin
      @(posedge clk);
      rxInBeat <= makeBeat(len, i);
    end
    @(posedge clk);
    rxInBeat <= '0;
    repeat (5) @(posedge clk);
  endtask
  initial begin
    #200000;
    badCount++;
    completeRun();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(txLocalFault, 1'b1, "localFault");
    busCycle(0, OFF_CTRL, 0, rd);
    check(rd, 32'h1, "ctrl reset");
    @(posedge clk);
    pcsAligned <= 1'b1;
    repeat (8) @(negedge clk);
    check(txLocalFault, 1'b0, "localFault");
    foreach (corner[k]) sendTx(corner[k], k[0], 1'b1);
    repeat (20) begin
      rnd = nextRand(rnd);
      sendTx(int'(rnd % 10000) + 1, rnd[20], rnd[21]);
    end
    for (int s = 0; s < 2; s++) foreach (rxLen[k]) begin
      busCycle(1, OFF_CTRL, 32'(1 + 4 * s), rd);
      rxBytes = 0;
      sendRx(rxLen[k]);
      check(rxBytes, rxLen[k] - ((s == 1 && rxLen[k] > 8) ? 4 : 0), "rx bytes");
      expRx++;
    end
    busCycle(1, OFF_CTRL, 32'h3, rd);
    rxBytes = 0;
    sendRx(40);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      rxBlkValid <= 1'b1;
      rxBlkIsIdle <= i > 2;
    end
    @(posedge clk);
    rxBlkValid <= 1'b0;
    busCycle(0, OFF_TESTERR, 0, rd);
    check(rd, 32'h3, "test errors");
    check(rxBytes, 0, "test mode drop");
    busCycle(1, OFF_TESTERR, 0, rd);
    busCycle(0, OFF_TESTERR, 0, rd);
    check(rd, 0, "test clear");
    busCycle(0, 4'hc, 0, rd);
    check(rd, 0, "unmapped");
    busCycle(1, OFF_CTRL, 32'h1, rd);
    rxBytes = 0;
    fork
      sendRx(100);
      begin
        repeat (2) @(posedge clk);
        busCycle(1, OFF_CTRL, 32'h0, rd);
      end
    join
    check(rxBytes, 100, "rx finish");
    expRx++;
    rxBytes = 0;
    sendRx(40);
    check(rxBytes, 0, "disabled rx");
    check(rxCount, expRx, "rx stats");
    check(txCount, expTx, "tx stats");
    @(posedge clk);
    ccPop <= 1'b1;
    @(posedge clk);
    ccPop <= 1'b0;
    repeat (2) @(negedge clk);
    check(txFifoError, 1'b1, "underflow");
    busCycle(0, OFF_STATUS, 0, rd);
    check(rd, 32'h1 << STAT_FIFOERR_BIT, "status");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(txFifoError, 1'b0, "after reset");
    @(posedge clk);
    ccPush <= 1'b1;
    repeat (16) @(posedge clk);
    ccPush <= 1'b0;
    @(negedge clk);
    check(txFifoError, 1'b0, "full fifo");
    @(posedge clk);
    ccPush <= 1'b1;
    @(posedge clk);
    ccPush <= 1'b0;
    repeat (2) @(negedge clk);
    check(txFifoError, 1'b1, "overflow");
    completeRun();
  end
endmodule // tb_eth_mac_tx_stats_rx_ctrl
